/* File: pal_pkg.sv */
// package: register map, field layout and timing constants of the palette access port
package pal_pkg;
  // register offsets from graphics_base (byte addresses)
  localparam logic [15:0] PAL_INDEX_OFS     = 16'h8370;
  localparam logic [15:0] PAL_DATA_OFS      = 16'h8374;
  // field layout
  localparam int          PAL_INDEX_W       = 9;
  localparam int          PAL_COLOR_W       = 18;
  localparam int          PAL_BUS_W         = 32;
  localparam int          PAL_ADDR_W        = 16;
  // index decode
  localparam logic [8:0]  PAL_STD_LAST      = 9'h0ff;
  localparam logic [8:0]  PAL_CURSOR0_IDX   = 9'h100;
  localparam logic [8:0]  PAL_CURSOR1_IDX   = 9'h101;
  localparam logic [8:0]  PAL_OVERSCAN_IDX  = 9'h104;
  localparam logic [8:0]  PAL_CURSOR0_SLOT  = 9'h100;
  localparam logic [8:0]  PAL_CURSOR1_SLOT  = 9'h101;
  localparam logic [8:0]  PAL_OVERSCAN_SLOT = 9'h102;
  localparam int          PAL_SLOTS         = 259;
  // reset values
  localparam logic [8:0]  PAL_INDEX_RST     = 9'h000;
  localparam logic [17:0] PAL_COLOR_RST     = 18'h00000;
  // timing: system clock and pixel clock periods in ns
  localparam int          PAL_CLK_NS        = 5;
  localparam int          PAL_PIX_NS        = 40;
  localparam int          PAL_PIX_DIV       = (PAL_PIX_NS + PAL_CLK_NS - 1) / PAL_CLK_NS;
endpackage

/* File: pal_clk_div.sv */
// pixel clock enable divider: one-cycle pulse every DIV clocks
`timescale 1ns/1ps
module pal_clk_div
  import pal_pkg::*;
#(
  parameter int DIV = PAL_PIX_DIV
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  initial begin
    if (DIV < 2) $error("pal_clk_div: DIV must be at least 2");
  end

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;

  // count down and pulse on wrap
  always_comb begin
    next_tick = (cnt == '0);
    next_cnt  = (cnt == '0) ? CW'(DIV - 1) : cnt - 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

  tick_spacing_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick |=> !tick) else $error("pixel enable longer than one cycle");
endmodule

/* File: pal_slot_map.sv */
// maps a palette index to a storage slot and flags locations that exist
`timescale 1ns/1ps
module pal_slot_map
  import pal_pkg::*;
(
  input  wire logic [8:0] index,
  output logic      [8:0] slot,
  output logic            valid
);
  // standard colours map straight, extensions pack after them
  always_comb begin
    slot  = index;
    valid = 1'b1;
    if (index <= PAL_STD_LAST) begin
      slot = index;
    end else if (index == PAL_CURSOR0_IDX) begin
      slot = PAL_CURSOR0_SLOT;
    end else if (index == PAL_CURSOR1_IDX) begin
      slot = PAL_CURSOR1_SLOT;
    end else if (index == PAL_OVERSCAN_IDX) begin
      slot = PAL_OVERSCAN_SLOT;
    end else begin
      slot  = '0;
      valid = 1'b0;
    end
  end
endmodule

/* File: pal_access_port.sv */
// palette access port: index and data registers over the colour lookup storage
// How it works
// - two 32-bit registers, the index at offset 8370h and the data at 8374h, sit on the register port.
// - the index register keeps a 9-bit location in bits 8:0 and reads zero above.
// - each read or write of the data register advances the index by one.
// - index 0h-FFh selects the standard colours, 100h and 101h the cursor colours, 104h the overscan colour.
// - the data register carries an 18-bit colour in bits 17:0, written to or read from the indexed entry.
// - a software access to the storage holds the pixel output for one extra pixel clock period.
`timescale 1ns/1ps
module pal_access_port
  import pal_pkg::*;
#(
  parameter int PIX_DIV = PAL_PIX_DIV
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [PAL_ADDR_W-1:0]  reg_addr,
  input  wire logic [PAL_BUS_W-1:0]   reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [PAL_BUS_W-1:0]   reg_rdata,
  input  wire logic [PAL_INDEX_W-1:0] lookup_index,
  output logic      [PAL_COLOR_W-1:0] pixel_color,
  output logic                        pixel_strobe
);

  // refuse settings that the divider, the read mux or the strobe gap counter cannot serve
  initial begin
    if (PIX_DIV < 2 || PIX_DIV > 255) $error("pal_access_port: PIX_DIV must lie in 2..255");
    if (PAL_BUS_W < PAL_COLOR_W || PAL_BUS_W < PAL_INDEX_W) $error("pal_access_port: bus narrower than a field");
    if (PAL_SLOTS <= int'(PAL_OVERSCAN_SLOT)) $error("pal_access_port: too few storage slots");
  end

  // address decode: unmapped offsets hit nothing, so writes vanish and reads give zero
  logic hit_index;
  logic hit_data;
  logic data_wr;
  logic data_rd;
  logic data_acc;

  always_comb begin
    hit_index = 1'b0;
    hit_data  = 1'b0;
    if (reg_addr == PAL_INDEX_OFS) begin
      hit_index = 1'b1;
    end else if (reg_addr == PAL_DATA_OFS) begin
      hit_data = 1'b1;
    end
    data_wr  = reg_wr & hit_data;
    data_rd  = reg_rd & hit_data;
    data_acc = data_wr | data_rd;
  end

  // pixel clock enable and index decoders: software and display each own a decoder,
  // so neither path waits for the other
  logic                   pix_tick;
  logic [8:0]             sw_slot;
  logic                   sw_valid;
  logic [8:0]             disp_slot;
  logic                   disp_valid;
  logic [PAL_INDEX_W-1:0] pal_index;

  pal_clk_div #(
    .DIV (PIX_DIV)
  ) u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (pix_tick)
  );

  pal_slot_map u_sw_map (
    .index (pal_index),
    .slot  (sw_slot),
    .valid (sw_valid)
  );

  pal_slot_map u_disp_map (
    .index (lookup_index),
    .slot  (disp_slot),
    .valid (disp_valid)
  );

  // index register: a load wins over the step and the step wraps 1FFh to 000h;
  // nothing else moves it, so software must reload it before any jump
  logic [PAL_INDEX_W-1:0] next_pal_index;

  // load from software, otherwise step after each data access
  always_comb begin
    next_pal_index = pal_index;
    if (reg_wr && hit_index) begin
      next_pal_index = reg_wdata[PAL_INDEX_W-1:0];
    end else if (data_acc) begin
      next_pal_index = pal_index + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pal_index <= PAL_INDEX_RST;
    end else begin
      pal_index <= next_pal_index;
    end
  end

  // colour storage: one write port for software, whole entry per cycle
  logic [PAL_COLOR_W-1:0] pal_mem [0:PAL_SLOTS-1];
  logic                   mem_we;

  always_comb begin
    mem_we = data_wr & sw_valid;
  end

  // an entry changes in one clock, so a lookup sees old or new, never a mix
  // reset clears every entry, so early reads and lookups return zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < PAL_SLOTS; i++) begin
        pal_mem[i] <= PAL_COLOR_RST;
      end
    end else if (mem_we) begin
      pal_mem[sw_slot] <= reg_wdata[PAL_COLOR_W-1:0];
    end
  end

  // read data, valid only in the cycle after the read strobe
  logic [PAL_BUS_W-1:0] next_reg_rdata;

  always_comb begin
    next_reg_rdata = '0;
    if (reg_rd && hit_index) begin
      next_reg_rdata = {{(PAL_BUS_W-PAL_INDEX_W){1'b0}}, pal_index};
    end else if (data_rd && sw_valid) begin
      next_reg_rdata = {{(PAL_BUS_W-PAL_COLOR_W){1'b0}}, pal_mem[sw_slot]};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // pixel path with hold after a software access: each pixel period with accesses costs one pixel
  // period of latency, traded for never showing an entry in mid-update
  logic                   hold_pend;
  logic                   next_hold_pend;
  logic [PAL_COLOR_W-1:0] next_pixel_color;
  logic                   next_pixel_strobe;
  logic                   hold_now;

  // an access pending or arriving at the tick skips one update
  always_comb begin
    hold_now          = hold_pend | data_acc;
    next_hold_pend    = hold_pend;
    next_pixel_color  = pixel_color;
    next_pixel_strobe = pix_tick;
    if (pix_tick) begin
      next_hold_pend = 1'b0;
      if (!hold_now) begin
        next_pixel_color = disp_valid ? pal_mem[disp_slot] : PAL_COLOR_RST;
      end
    end else if (data_acc) begin
      next_hold_pend = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_pend    <= 1'b0;
      pixel_color  <= PAL_COLOR_RST;
      pixel_strobe <= 1'b0;
    end else begin
      hold_pend    <= next_hold_pend;
      pixel_color  <= next_pixel_color;
      pixel_strobe <= next_pixel_strobe;
    end
  end

  // cycles since the last pixel strobe, read only by the checks below; it
  // saturates so a long run cannot wrap it into a false match
  logic [7:0] strobe_gap;
  logic [7:0] next_strobe_gap;

  always_comb begin
    next_strobe_gap = strobe_gap;
    if (pixel_strobe) begin
      next_strobe_gap = 8'h01;
    end else if (strobe_gap != 8'hff) begin
      next_strobe_gap = strobe_gap + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strobe_gap <= 8'h00;
    end else begin
      strobe_gap <= next_strobe_gap;
    end
  end

  // assertions and cover points
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  index_step_a: assert property (
    data_acc && !(reg_wr && hit_index) |=> pal_index == $past(pal_index) + 9'h001)
    else $error("index did not advance after a data access");

  index_load_a: assert property (
    reg_wr && hit_index |=> pal_index == $past(reg_wdata[8:0]))
    else $error("index load lost");

  index_read_a: assert property (
    reg_rd && hit_index |=> reg_rdata == {23'h0, $past(pal_index)})
    else $error("index read returned wrong value");

  data_rw_a: assert property (
    data_wr && sw_valid ##1 (reg_wr && hit_index && reg_wdata[8:0] == $past(pal_index)) ##1 data_rd
    |=> reg_rdata[17:0] == $past(reg_wdata[17:0], 3))
    else $error("data write not read back");

  rsvd_zero_a: assert property (
    reg_rdata[31:18] == 14'h0)
    else $error("reserved data bits not zero");

  invalid_drop_a: assert property (
    data_rd && !sw_valid |=> reg_rdata == 32'h00000000)
    else $error("read of missing location returned data");

  overscan_map_a: assert property (
    pal_index == PAL_OVERSCAN_IDX |-> sw_valid && sw_slot == PAL_OVERSCAN_SLOT)
    else $error("overscan index decoded wrongly");

  pixel_hold_a: assert property (
    pix_tick && hold_now |=> $stable(pixel_color) && !hold_pend)
    else $error("pixel output not held after access");

  pixel_update_a: assert property (
    pix_tick && !hold_now && disp_valid ##1 !mem_we
    |-> pixel_color == pal_mem[$past(disp_slot)])
    else $error("pixel output not taken from storage");

  hold_set_a: assert property (
    data_acc && !pix_tick |=> hold_pend)
    else $error("access did not arm the hold");

  rd_once_a: assert property (
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not cleared");

  // index register and unmapped read checks
  index_keep_a: assert property (
    !(reg_wr && hit_index) && !data_acc |=> $stable(pal_index))
    else $error("index moved without an access");

  index_wrap_a: assert property (
    data_acc && pal_index == '1 |=> pal_index == '0)
    else $error("index did not wrap to zero");

  unmapped_rd_a: assert property (
    reg_rd && !hit_index && !hit_data |=> reg_rdata == 32'h00000000)
    else $error("unmapped read returned data");

  // decoder checks
  std_map_a: assert property (
    pal_index <= PAL_STD_LAST |-> sw_valid && sw_slot == pal_index)
    else $error("standard colour index decoded wrongly");

  cursor0_map_a: assert property (
    pal_index == PAL_CURSOR0_IDX |-> sw_valid && sw_slot == PAL_CURSOR0_SLOT)
    else $error("cursor colour 0 index decoded wrongly");

  cursor1_map_a: assert property (
    pal_index == PAL_CURSOR1_IDX |-> sw_valid && sw_slot == PAL_CURSOR1_SLOT)
    else $error("cursor colour 1 index decoded wrongly");

  rsvd_map_a: assert property (
    (pal_index > PAL_CURSOR1_IDX && pal_index < PAL_OVERSCAN_IDX) || pal_index > PAL_OVERSCAN_IDX |-> !sw_valid)
    else $error("missing location decoded as storage");

  // storage and pixel path checks
  mem_write_a: assert property (
    mem_we |=> pal_mem[$past(sw_slot)] == $past(reg_wdata[17:0]))
    else $error("data write did not land");

  color_keep_a: assert property (
    !pix_tick |=> $stable(pixel_color))
    else $error("pixel output changed off the pixel clock");

  strobe_pulse_a: assert property (
    pixel_strobe |=> !pixel_strobe)
    else $error("pixel strobe longer than one cycle");

  strobe_gap_a: assert property (
    pixel_strobe && strobe_gap != 8'h00 |-> strobe_gap == 8'(PIX_DIV))
    else $error("pixel strobes not spaced by the divider");

  data_write_c: cover property (data_wr && sw_valid);
  data_read_c:  cover property (data_rd && sw_valid);
  hold_c:       cover property (pix_tick && hold_now);
  wrap_c:       cover property (data_acc && pal_index == 9'h1ff);
  pend_hold_c:  cover property (data_acc && !pix_tick ##1 pix_tick && hold_pend);
endmodule

/* File: pal_access_port_tb_top.sv */
// self-checking testbench of the palette access port
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((ex) !== (got)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module pal_access_port_tb_top
  import pal_pkg::*;
;
  logic                   clk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic [PAL_ADDR_W-1:0]  reg_addr = '0;
  logic [PAL_BUS_W-1:0]   reg_wdata = '0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [PAL_BUS_W-1:0]   reg_rdata;
  logic [PAL_INDEX_W-1:0] lookup_index = '0;
  logic [PAL_COLOR_W-1:0] pixel_color;
  logic                   pixel_strobe;
  logic [17:0]            mem [0:511];
  logic [8:0]             idx_m = 9'h000;
  int                     seed = 32'h2ea3;
  int                     miscompares = 0;
  int                     tests_run = 0;

  pal_access_port #(.PIX_DIV(2)) pal_access_port_inst (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lookup_index(lookup_index), .pixel_color(pixel_color),
    .pixel_strobe(pixel_strobe));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // locations that hold storage
  function automatic logic ok(input logic [8:0] i);
    return (i <= PAL_CURSOR1_IDX) || (i == PAL_OVERSCAN_IDX);
  endfunction

  // expected read data of the data register at the model index
  function automatic logic [31:0] exp_data();
    return ok(idx_m) ? {14'h0, mem[idx_m]} : 32'h0000_0000;
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one write cycle, model follows
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; reg_rd <= 1'b0;
    if (a == PAL_DATA_OFS) begin
      if (ok(idx_m)) mem[idx_m] = d[17:0];
      idx_m = idx_m + 9'h001;
    end else if (a == PAL_INDEX_OFS) idx_m = d[8:0];
    @(posedge clk);
  endtask

  // one read cycle, data checked in the following cycle
  task automatic rd(input logic [15:0] a);
    logic [31:0] ex;
    ex = 32'h0000_0000;
    if (a == PAL_DATA_OFS) begin
      ex = exp_data();
      idx_m = idx_m + 9'h001;
    end else if (a == PAL_INDEX_OFS) ex = {23'h0, idx_m};
    reg_addr <= a; reg_rd <= 1'b1; reg_wr <= 1'b0;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK("reg_rdata", ex, reg_rdata)
    @(posedge clk);
  endtask

  // bounded wait for the next pixel strobe
  task automatic wait_strobe;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pixel_strobe !== 1'b1 && n < 40);
    if (pixel_strobe !== 1'b1) begin miscompares++; summarize(); end
  endtask

  // global watchdog
  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    summarize();
  end

  // main sequence
  initial begin
    logic [8:0]  st;
    logic [8:0]  b;
    logic [17:0] v;
    for (int i = 0; i < 512; i++) mem[i] = PAL_COLOR_RST;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(PAL_INDEX_OFS);
    rd(PAL_DATA_OFS);
    wr(PAL_INDEX_OFS, 32'hffff_fe37);
    rd(PAL_INDEX_OFS);
    $display("test reset and index done");
    // blocks of writes then reads, crossing cursor, reserved and invalid locations
    for (int r = 0; r < 7; r++) begin
      st = (r == 0) ? 9'h0fc : (r == 1) ? 9'h100 : (r == 2) ? 9'h1fc : 9'($random(seed) & 32'hf0);
      wr(PAL_INDEX_OFS, {$random(seed)} & 32'hffff_fe00 | {23'h0, st});
      for (int k = 0; k < 9; k++) wr(PAL_DATA_OFS, $random(seed));
      wr(PAL_INDEX_OFS, {23'h0, st});
      for (int k = 0; k < 9; k++) rd(PAL_DATA_OFS);
      rd(PAL_INDEX_OFS);
    end
    // write one entry, reload the same location and read it straight back
    wr(PAL_INDEX_OFS, 32'h0000_0050);
    wr(PAL_DATA_OFS, $random(seed));
    wr(PAL_INDEX_OFS, 32'h0000_0050);
    rd(PAL_DATA_OFS);
    $display("test data blocks done");
    wr(16'h8378, $random(seed));
    rd(16'h8378);
    rd(PAL_INDEX_OFS);
    $display("test unmapped done");
    // pixel hold on a read access, then on a write access
    for (int k = 0; k < 2; k++) begin
      b = k ? 9'h0ff : 9'($random(seed) & 32'h7f);
      v = 18'($random(seed));
      wr(PAL_INDEX_OFS, {23'h0, b + 9'h002});
      wr(PAL_DATA_OFS, {14'h0, v});
      wr(PAL_INDEX_OFS, {23'h0, b});
      wr(PAL_DATA_OFS, {14'h0, ~v});
      reg_wr <= 1'b0;
      lookup_index <= b + 9'h002;
      repeat (3) wait_strobe();
      `CHK("pixel_color", mem[b + 9'h002], pixel_color)
      @(posedge clk);
      // the second pass makes its access between ticks, so the hold waits pending
      if (k == 1) @(posedge clk);
      lookup_index <= b; reg_addr <= PAL_DATA_OFS; reg_wdata <= 32'h0001_2345;
      reg_rd <= (k == 0); reg_wr <= (k == 1);
      if (k == 1 && ok(idx_m)) mem[idx_m] = 18'h12345;
      idx_m = idx_m + 9'h001;
      @(posedge clk);
      reg_rd <= 1'b0; reg_wr <= 1'b0;
      wait_strobe();
      `CHK("pixel_color held", mem[b + 9'h002], pixel_color)
      wait_strobe();
      `CHK("pixel_color next", mem[b], pixel_color)
      @(posedge clk);
    end
    $display("test pixel hold done");
    summarize();
  end
endmodule
